// ---- logic/rmsc_fifo.sv ----
`timescale 1ns/1ns
module rmsc_fifo #(
  parameter int W = $bits(rmsc_pkg::rmsc_req_t),
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  rmsc_req_if.src out_if
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, rd_q;
  logic [CW-1:0] cnt_q, cnt_d;
  logic in_ready_q, out_valid_q;
  logic push, pop;

  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
    nxt = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  assign push = in_valid & in_ready_q;
  assign pop = out_valid_q & out_if.ready;
  assign cnt_d = cnt_q + CW'(push) - CW'(pop);
  assign in_ready = in_ready_q;
  assign out_if.valid = out_valid_q;
  assign out_if.req = mem_q[rd_q];

  always_ff @(posedge mclk) begin
    if (ce && push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_q <= 1'b1;
      out_valid_q <= 1'b0;
    end else if (ce) begin
      if (push) wr_q <= nxt(wr_q);
      if (pop) rd_q <= nxt(rd_q);
      cnt_q <= cnt_d;
      in_ready_q <= cnt_d != CW'(DEPTH);
      out_valid_q <= cnt_d != '0;
    end
  end

  a_fifo_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    cnt_q <= CW'(DEPTH)) else $error("fifo count past depth");
endmodule

// ---- logic/rmsc_if.sv ----
`timescale 1ns/1ns
interface rmsc_req_if;
  rmsc_pkg::rmsc_req_t req;
  logic valid;
  logic ready;
  modport src(output req, output valid, input ready);
  modport snk(input req, input valid, output ready);
endinterface

interface rmsc_ph_if #(parameter int DRV_W = 8);
  logic [2:0] phase;
  logic [4:0] done;
  logic [DRV_W-1:0] drv_sel;
  modport drv(output phase, output done, output drv_sel);
  modport mon(input phase, input done, input drv_sel);
endinterface

// ---- logic/rmsc_master.sv ----
`timescale 1ns/1ns
`include "rmsc_params.svh"
module rmsc_master #(
  parameter int DRV_W = 8,
  parameter int LAD_DEPTH = `RMSC_LAD_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // ring pins
  input wire logic ring_ok_pin,
  input wire logic drv_ack_pin,
  // cycle timing and telegrams
  input wire logic cyc_start,
  input wire logic at_last,
  input wire logic [15:0] at_sc_word,
  output logic mst_send,
  output logic mdt_send,
  output logic [15:0] mdt_sc_word,
  output logic cyc_xfer,
  output logic [15:0] tg_len,
  // startup
  input wire logic hold_cfg,
  input wire logic cont_req,
  input wire logic step_done,
  input wire logic [DRV_W-1:0] num_drv,
  output logic [2:0] phase,
  output logic [4:0] phase_done,
  output logic [DRV_W-1:0] drv_sel,
  // cyclic layout
  input wire logic cyc_cfg_wr,
  input wire logic [2:0] cyc_cfg_element_selector,
  input wire logic [7:0] cyc_cfg_words,
  output logic cyc_cfg_rej,
  output logic [7:0] cyc_words,
  // ladder requests
  input wire logic lad_valid,
  input wire rmsc_pkg::rmsc_req_t lad_req,
  output logic lad_ready,
  output logic lad_rej,
  // setup tool requests
  input wire logic tool_valid,
  input wire rmsc_pkg::rmsc_req_t tool_req,
  output logic tool_ready,
  // answers
  output logic rsp_valid,
  output logic rsp_tool,
  output logic [15:0] rsp_data,
  // procedure command
  input wire logic pc_start,
  input wire logic [15:0] pc_idn,
  output logic pc_busy,
  output logic pc_done,
  output logic pc_err,
  output logic [`RMSC_PC_ST_W-1:0] pc_status
);
  logic [2:0] ring_s_q, ack_s_q;
  logic ring_f_q, ack_f_q;
  rmsc_pkg::rmsc_cy_t cy_q;
  logic mst_q, mdt_q, cyc_xfer_q;
  logic [15:0] mdt_word_q, tg_len_q;
  logic [7:0] cyc_words_q;
  logic cyc_rej_q, lad_rej_q, tool_rdy_q;
  logic sc_busy_q;
  logic [1:0] step_q;
  rmsc_pkg::rmsc_src_t src_q;
  rmsc_pkg::rmsc_req_t cur_q, pc_req;
  logic rsp_v_q, rsp_tool_q;
  logic [15:0] rsp_data_q;
  rmsc_pkg::rmsc_pc_t pc_q;
  logic pc_issued_q, pc_done_q, pc_err_q, pc_busy_q;
  logic [2:0] phase_q;
  logic [`RMSC_PC_ST_W-1:0] pc_st_q;
  logic sc_ok, cyc_ok, start, pick_lad, pick_pc, pick_tool, fin;
  logic pc_want;

  rmsc_ph_if #(.DRV_W(DRV_W)) ph_if();
  rmsc_req_if lad_if();

  // pins: three stages, taken once the last two agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ring_s_q <= 3'h0;
      ack_s_q <= 3'h0;
      ring_f_q <= 1'b0;
      ack_f_q <= 1'b0;
    end else if (ce) begin
      ring_s_q <= {ring_s_q[1:0], ring_ok_pin};
      ack_s_q <= {ack_s_q[1:0], drv_ack_pin};
      if (ring_s_q[1] == ring_s_q[2]) ring_f_q <= ring_s_q[2];
      if (ack_s_q[1] == ack_s_q[2]) ack_f_q <= ack_s_q[2];
    end
  end

  rmsc_phase #(.DRV_W(DRV_W)) u_phase (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .ring_ok(ring_f_q),
    .drv_ack(ack_f_q),
    .cyc_tick(cyc_start),
    .step_done(step_done),
    .hold_cfg(hold_cfg),
    .cont_req(cont_req),
    .num_drv(num_drv),
    .ph(ph_if.drv)
  );

  rmsc_fifo #(.W($bits(rmsc_pkg::rmsc_req_t)), .DEPTH(LAD_DEPTH)) u_lad_q (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(lad_valid),
    .in_data(lad_req),
    .in_ready(lad_ready),
    .out_if(lad_if.src)
  );

  assign sc_ok = ph_if.done[`RMSC_PH_HOLD_AT];
  assign cyc_ok = ph_if.done[`RMSC_PH_LAST];
  // phase number is decoded in the sequencer; register it for a clean pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 3'h0;
    end else if (ce) begin
      phase_q <= ph_if.phase;
    end
  end

  assign phase = phase_q;
  assign phase_done = ph_if.done;
  assign drv_sel = ph_if.drv_sel;

  // transfers open only at a cycle boundary, one at a time
  assign start = ce && cyc_start && cy_q == rmsc_pkg::CY_IDLE && !sc_busy_q && sc_ok;
  assign pc_want = pc_q != rmsc_pkg::PC_IDLE && !pc_issued_q;
  assign pick_lad = start && lad_if.valid;
  assign pick_pc = start && !lad_if.valid && pc_want;
  assign pick_tool = start && !lad_if.valid && !pc_want && tool_valid;
  assign lad_if.ready = pick_lad;
  assign fin = ce && at_last && cy_q == rmsc_pkg::CY_WAIT_AT && sc_busy_q
    && step_q == `RMSC_SC_LAST_STEP;

  always_comb begin
    pc_req.wr = pc_q != rmsc_pkg::PC_POLL;
    pc_req.element_selector = `RMSC_ELEMENT_SELECTOR_OPDATA;
    pc_req.idn = pc_idn;
    pc_req.data = (pc_q == rmsc_pkg::PC_SET) ? `RMSC_PC_SET_VAL : `RMSC_PC_CLR_VAL;
  end

  // telegram order within a cycle: sync, drive telegrams, then data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cy_q <= rmsc_pkg::CY_IDLE;
      mst_q <= 1'b0;
      mdt_q <= 1'b0;
      cyc_xfer_q <= 1'b0;
    end else if (ce) begin
      mst_q <= 1'b0;
      mdt_q <= 1'b0;
      cyc_xfer_q <= 1'b0;
      unique case (cy_q)
        rmsc_pkg::CY_IDLE: if (cyc_start) begin
          mst_q <= 1'b1;
          cy_q <= rmsc_pkg::CY_WAIT_AT;
        end
        rmsc_pkg::CY_WAIT_AT: if (at_last) begin
          mdt_q <= 1'b1;
          cyc_xfer_q <= cyc_ok;
          cy_q <= rmsc_pkg::CY_IDLE;
        end
      endcase
    end
  end

  // length fixed by the layout; the service word is always counted
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tg_len_q <= `RMSC_SC_WORDS;
    end else if (ce) begin
      tg_len_q <= `RMSC_SC_WORDS + (cyc_ok ? {8'h00, cyc_words_q} : 16'h0000);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_words_q <= 8'h00;
      cyc_rej_q <= 1'b0;
    end else if (ce) begin
      cyc_rej_q <= 1'b0;
      if (cyc_cfg_wr) begin
        if (cyc_ok || cyc_cfg_element_selector != `RMSC_ELEMENT_SELECTOR_OPDATA) begin
          cyc_rej_q <= 1'b1;
        end else begin
          cyc_words_q <= cyc_cfg_words;
        end
      end
    end
  end

  // service engine: idn, element, data out; answer in the next drive telegram
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sc_busy_q <= 1'b0;
      step_q <= 2'h0;
      src_q <= rmsc_pkg::SRC_LAD;
      cur_q <= '0;
      mdt_word_q <= 16'h0000;
    end else if (ce) begin
      if (pick_lad || pick_pc || pick_tool) begin
        sc_busy_q <= 1'b1;
        step_q <= 2'h0;
        src_q <= pick_lad ? rmsc_pkg::SRC_LAD
          : (pick_pc ? rmsc_pkg::SRC_PROC : rmsc_pkg::SRC_TOOL);
        cur_q <= pick_lad ? lad_if.req : (pick_pc ? pc_req : tool_req);
      end else if (at_last && cy_q == rmsc_pkg::CY_WAIT_AT) begin
        mdt_word_q <= 16'h0000;
        if (sc_busy_q) begin
          unique case (step_q)
            2'h0: mdt_word_q <= cur_q.idn;
            2'h1: mdt_word_q <= {12'h000, cur_q.element_selector, cur_q.wr};
            2'h2: mdt_word_q <= cur_q.wr ? cur_q.data : 16'h0000;
            2'h3: sc_busy_q <= 1'b0;
          endcase
          if (step_q != `RMSC_SC_LAST_STEP) step_q <= step_q + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_v_q <= 1'b0;
      rsp_tool_q <= 1'b0;
      rsp_data_q <= 16'h0000;
      tool_rdy_q <= 1'b0;
      lad_rej_q <= 1'b0;
    end else if (ce) begin
      tool_rdy_q <= pick_tool;
      lad_rej_q <= lad_valid && !lad_ready;
      rsp_v_q <= fin && src_q != rmsc_pkg::SRC_PROC;
      if (fin) begin
        rsp_tool_q <= src_q == rmsc_pkg::SRC_TOOL;
        rsp_data_q <= at_sc_word;
      end
    end
  end

  // procedure handshake: set, poll until finished or failed, then cancel
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= rmsc_pkg::PC_IDLE;
      pc_busy_q <= 1'b0;
      pc_issued_q <= 1'b0;
      pc_done_q <= 1'b0;
      pc_err_q <= 1'b0;
      pc_st_q <= '0;
    end else if (ce) begin
      pc_done_q <= 1'b0;
      if (pick_pc) pc_issued_q <= 1'b1;
      if (pc_q == rmsc_pkg::PC_IDLE && pc_start) begin
        pc_q <= rmsc_pkg::PC_SET;
        pc_busy_q <= 1'b1;
        pc_err_q <= 1'b0;
      end else if (fin && src_q == rmsc_pkg::SRC_PROC) begin
        pc_issued_q <= 1'b0;
        unique case (pc_q)
          rmsc_pkg::PC_SET: pc_q <= rmsc_pkg::PC_POLL;
          rmsc_pkg::PC_POLL: begin
            pc_st_q <= at_sc_word[`RMSC_PC_ST_W-1:0];
            // change flag in bit five must not hide a finished status
            if (at_sc_word[4:0] == 5'(`RMSC_PC_OK_VAL) || at_sc_word[`RMSC_PC_BIT_ERR]) begin
              pc_err_q <= at_sc_word[`RMSC_PC_BIT_ERR];
              pc_q <= rmsc_pkg::PC_CLR;
            end
          end
          rmsc_pkg::PC_CLR: begin
            pc_q <= rmsc_pkg::PC_IDLE;
            pc_busy_q <= 1'b0;
            pc_done_q <= 1'b1;
          end
          default: begin
            pc_q <= rmsc_pkg::PC_IDLE;
            pc_busy_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign mst_send = mst_q;
  assign mdt_send = mdt_q;
  assign mdt_sc_word = mdt_word_q;
  assign cyc_xfer = cyc_xfer_q;
  assign tg_len = tg_len_q;
  assign cyc_cfg_rej = cyc_rej_q;
  assign cyc_words = cyc_words_q;
  assign lad_rej = lad_rej_q;
  assign tool_ready = tool_rdy_q;
  assign rsp_valid = rsp_v_q;
  assign rsp_tool = rsp_tool_q;
  assign rsp_data = rsp_data_q;
  assign pc_busy = pc_busy_q;
  assign pc_done = pc_done_q;
  assign pc_err = pc_err_q;
  assign pc_status = pc_st_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_sync_sent: assert property (ce && cyc_start && cy_q == rmsc_pkg::CY_IDLE |=> mst_q)
    else $error("no sync telegram at cycle start");
  a_mdt_after_at: assert property (mdt_q |-> $past(at_last) && $past(ce))
    else $error("data telegram before last drive telegram");
  a_cyc_gate: assert property (cyc_xfer_q |-> phase_done[4])
    else $error("cyclic data before phase four");
  a_cyc_freeze: assert property (ce && cyc_ok |=> $stable(cyc_words_q))
    else $error("cyclic layout changed after phase four");
  a_sc_gate: assert property ($rose(sc_busy_q) |-> phase_done[2])
    else $error("service transfer before phase two");
  a_one_req: assert property (sc_busy_q && !fin |-> !start)
    else $error("second service request started");
  a_lad_first: assert property (start && lad_if.valid |-> !pick_tool ##1 src_q == rmsc_pkg::SRC_LAD)
    else $error("tool served ahead of ladder queue");
  a_lad_reject: assert property (ce && lad_valid && !lad_ready |=> lad_rej_q)
    else $error("full queue did not refuse");
  a_pc_set_val: assert property (pick_pc && pc_q == rmsc_pkg::PC_SET |=> cur_q.wr && cur_q.data == 16'h0003)
    else $error("procedure not started with three");
  a_pc_cancel: assert property (fin && src_q == rmsc_pkg::SRC_PROC && pc_q == rmsc_pkg::PC_POLL
    && (at_sc_word[4:0] == 5'h03 || at_sc_word[3]) |=> pc_q == rmsc_pkg::PC_CLR)
    else $error("finished procedure not cancelled");
  a_len_fixed: assert property (ce && !cyc_ok && !$past(cyc_ok) |=> tg_len_q == 16'h0001)
    else $error("telegram length moved with service activity");

  c_lad_done: cover property (rsp_v_q && !rsp_tool_q);
  c_tool_done: cover property (rsp_v_q && rsp_tool_q);
  c_pc_done: cover property (pc_done_q && !pc_err_q);
  c_pc_fail: cover property (pc_done_q && pc_err_q);
endmodule

// ---- logic/rmsc_params.svh ----
`ifndef RMSC_PARAMS_SVH
`define RMSC_PARAMS_SVH
// procedure command handshake values and bits
`define RMSC_PC_SET_VAL 16'h0003
`define RMSC_PC_CLR_VAL 16'h0000
`define RMSC_PC_OK_VAL 16'h0003
`define RMSC_PC_BIT_ERR 3
`define RMSC_PC_BIT_CHG 5
`define RMSC_PC_ST_W 6
// element selectors
`define RMSC_ELEMENT_SELECTOR_OPDATA 3'h1
// telegram and service channel
`define RMSC_SC_WORDS 16'h0001
`define RMSC_SC_LAST_STEP 2'h3
`define RMSC_LAD_DEPTH 16
// phase numbers
`define RMSC_PH_HOLD_AT 2
`define RMSC_PH_LAST 4
`endif

// ---- logic/rmsc_phase.sv ----
`timescale 1ns/1ns
`include "rmsc_params.svh"
module rmsc_phase #(
  parameter int DRV_W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // ring state and drive acknowledge, filtered; cycle tick unfiltered
  input wire logic ring_ok,
  input wire logic drv_ack,
  input wire logic cyc_tick,
  // startup control
  input wire logic step_done,
  input wire logic hold_cfg,
  input wire logic cont_req,
  input wire logic [DRV_W-1:0] num_drv,
  // status
  rmsc_ph_if.drv ph
);
  rmsc_pkg::rmsc_ph_t st_q;
  logic [4:0] done_q;
  logic [DRV_W-1:0] idx_q;
  logic ack_d1_q;
  logic ack_rise;

  assign ack_rise = drv_ack & ~ack_d1_q;
  assign ph.done = done_q;
  assign ph.drv_sel = idx_q;

  always_comb begin
    unique case (st_q)
      rmsc_pkg::PH_P0: ph.phase = 3'h0;
      rmsc_pkg::PH_P1: ph.phase = 3'h1;
      rmsc_pkg::PH_P2, rmsc_pkg::PH_HOLD: ph.phase = 3'h2;
      rmsc_pkg::PH_P3: ph.phase = 3'h3;
      default: ph.phase = 3'h4;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_d1_q <= 1'b0;
    end else if (ce) begin
      ack_d1_q <= drv_ack;
    end
  end

  // losing the ring restarts the whole climb from phase 0
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= rmsc_pkg::PH_P0;
      done_q <= 5'h00;
      idx_q <= '0;
    end else if (ce) begin
      if (!ring_ok && st_q != rmsc_pkg::PH_P0) begin
        st_q <= rmsc_pkg::PH_P0;
        done_q <= 5'h00;
        idx_q <= '0;
      end else begin
        unique case (st_q)
          rmsc_pkg::PH_P0: if (cyc_tick && ring_ok) begin
            done_q[0] <= 1'b1;
            idx_q <= '0;
            st_q <= rmsc_pkg::PH_P1;
          end
          rmsc_pkg::PH_P1: if (ack_rise) begin
            if (idx_q + DRV_W'(1) >= num_drv) begin
              done_q[1] <= 1'b1;
              st_q <= rmsc_pkg::PH_P2;
            end else begin
              idx_q <= idx_q + DRV_W'(1);
            end
          end
          rmsc_pkg::PH_P2: if (step_done) begin
            done_q[`RMSC_PH_HOLD_AT] <= 1'b1;
            st_q <= hold_cfg ? rmsc_pkg::PH_HOLD : rmsc_pkg::PH_P3;
          end
          rmsc_pkg::PH_HOLD: if (cont_req) begin
            st_q <= rmsc_pkg::PH_P3;
          end
          rmsc_pkg::PH_P3: if (step_done) begin
            done_q[3] <= 1'b1;
            st_q <= rmsc_pkg::PH_P4;
          end
          rmsc_pkg::PH_P4: if (step_done) begin
            done_q[`RMSC_PH_LAST] <= 1'b1;
            st_q <= rmsc_pkg::PH_RUN;
          end
          rmsc_pkg::PH_RUN: ;
        endcase
      end
    end
  end

  a_phase_step: assert property (@(posedge mclk) disable iff (!rst_n)
    ph.phase != $past(ph.phase) |->
      ph.phase == $past(ph.phase) + 3'h1 || ph.phase == 3'h0)
    else $error("phase skipped");
  a_hold_wait: assert property (@(posedge mclk) disable iff (!rst_n)
    st_q == rmsc_pkg::PH_HOLD && !cont_req && ring_ok |=>
      st_q == rmsc_pkg::PH_HOLD) else $error("hold left without continue");
  c_reach_run: cover property (@(posedge mclk) disable iff (!rst_n)
    st_q == rmsc_pkg::PH_RUN);
endmodule

// ---- logic/rmsc_pkg.sv ----
package rmsc_pkg;
  typedef struct packed {
    logic wr;
    logic [2:0] element_selector;
    logic [15:0] idn;
    logic [15:0] data;
  } rmsc_req_t;
  typedef enum logic [2:0] {PH_P0, PH_P1, PH_P2, PH_HOLD, PH_P3, PH_P4, PH_RUN} rmsc_ph_t;
  typedef enum logic {CY_IDLE, CY_WAIT_AT} rmsc_cy_t;
  typedef enum logic [2:0] {PC_IDLE, PC_SET, PC_POLL, PC_CLR} rmsc_pc_t;
  typedef enum logic [1:0] {SRC_LAD, SRC_TOOL, SRC_PROC} rmsc_src_t;
endpackage

// ---- tb/rmsc_drive_model.sv ----
`timescale 1ns/1ns
module rmsc_drive_model #(
  parameter logic [15:0] PC_IDN = 16'h0106
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // master side
  input wire logic mst_send,
  input wire logic mdt_send,
  input wire logic [15:0] mdt_sc_word,
  input wire logic [2:0] phase,
  input wire logic [7:0] drv_sel,
  // drive side
  input wire logic fail,
  output logic at_last,
  output logic [15:0] at_sc_word,
  output logic drv_ack_pin,
  output logic [15:0] status_q
);
  logic [1:0] dly_q;
  logic [15:0] w0_q, w1_q, w2_q;
  logic [2:0] run_q;
  logic [3:0] ack_q;
  logic [7:0] sel_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {dly_q, at_last, at_sc_word, w0_q, w1_q, w2_q} <= '0;
      {status_q, run_q, ack_q, sel_q, drv_ack_pin} <= '0;
    end else begin
      dly_q <= {dly_q[0], mst_send};
      at_last <= dly_q[1];
      // reply word: status for the procedure, a mark of the idn otherwise
      if (dly_q[1])
        at_sc_word <= (w2_q == PC_IDN) ? status_q : w2_q ^ 16'h00ff;
      else
        at_sc_word <= ~at_sc_word;
      if (mdt_send) begin
        w0_q <= mdt_sc_word;
        w1_q <= w0_q;
        w2_q <= w1_q;
        // control bit 0 of the word before the data marks a write
        if (w1_q == PC_IDN && w0_q[0]) begin
          if (mdt_sc_word == 16'h0003) begin
            status_q <= 16'h0007;
            run_q <= 3'h4;
          end else if (mdt_sc_word == 16'h0000) begin
            status_q <= 16'h0000;
          end
        end else if (status_q == 16'h0007) begin
          if (run_q == 3'h0)
            // change flag raised together with the end status
            status_q <= fail ? 16'h002b : 16'h0023;
          else
            run_q <= run_q - 3'h1;
        end
      end
      // one acknowledge rise for each drive addressed
      sel_q <= drv_sel;
      if (phase != 3'h1 || sel_q != drv_sel)
        ack_q <= 4'h0;
      else if (ack_q != 4'hf)
        ack_q <= ack_q + 4'h1;
      drv_ack_pin <= ack_q >= 4'h4 && ack_q < 4'hc;
    end
  end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  localparam logic [15:0] PC_IDN = 16'h0106;
  logic mclk, rst_n, ce, ring_ok_pin, cyc_start, hold_cfg, cont_req, step_done;
  logic fail, cyc_cfg_wr, lad_valid, tool_valid, pc_start, cyc_en, rej;
  logic drv_ack_pin, at_last, mst_send, mdt_send, cyc_xfer, cyc_cfg_rej, lad_ready;
  logic lad_rej, tool_ready, rsp_valid, rsp_tool, pc_busy, pc_done, pc_err;
  logic [2:0] cyc_cfg_element_selector, cnt_q, phase;
  logic [4:0] phase_done;
  logic [5:0] pc_status;
  logic [7:0] num_drv, cyc_cfg_words, drv_sel, cyc_words;
  logic [15:0] pc_idn, at_sc_word, mdt_sc_word, tg_len, rsp_data, status_q;
  rmsc_pkg::rmsc_req_t lad_req, tool_req;
  int mismatches, compares, rej_n, early_n, xfer_n, run_n, acc, i;
  logic [16:0] rsp_q[$];

  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cnt_q <= cnt_q + 3'h1;
    cyc_start <= cyc_en && cnt_q == 3'h0;
    if (rsp_valid === 1'b1) rsp_q.push_back({rsp_tool, rsp_data});
    if (lad_rej === 1'b1) rej_n++;
    if (cyc_xfer === 1'b1) xfer_n++;
    if (cyc_xfer === 1'b1 && phase_done[4] !== 1'b1) early_n++;
    if (status_q === 16'h0007) run_n++;
  end

  rmsc_master #(.DRV_W(8)) i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .ring_ok_pin(ring_ok_pin), .drv_ack_pin(drv_ack_pin), .cyc_start(cyc_start),
    .at_last(at_last), .at_sc_word(at_sc_word), .mst_send(mst_send), .mdt_send(mdt_send),
    .mdt_sc_word(mdt_sc_word), .cyc_xfer(cyc_xfer), .tg_len(tg_len), .hold_cfg(hold_cfg),
    .cont_req(cont_req), .step_done(step_done), .num_drv(num_drv), .phase(phase),
    .phase_done(phase_done), .drv_sel(drv_sel), .cyc_cfg_wr(cyc_cfg_wr),
    .cyc_cfg_element_selector(cyc_cfg_element_selector), .cyc_cfg_words(cyc_cfg_words), .cyc_cfg_rej(cyc_cfg_rej),
    .cyc_words(cyc_words), .lad_valid(lad_valid), .lad_req(lad_req), .lad_ready(lad_ready),
    .lad_rej(lad_rej), .tool_valid(tool_valid), .tool_req(tool_req),
    .tool_ready(tool_ready), .rsp_valid(rsp_valid), .rsp_tool(rsp_tool),
    .rsp_data(rsp_data), .pc_start(pc_start), .pc_idn(pc_idn), .pc_busy(pc_busy),
    .pc_done(pc_done), .pc_err(pc_err), .pc_status(pc_status));

  rmsc_drive_model #(.PC_IDN(PC_IDN)) i_drv (.mclk(mclk), .rst_n(rst_n),
    .mst_send(mst_send), .mdt_send(mdt_send), .mdt_sc_word(mdt_sc_word), .phase(phase),
    .drv_sel(drv_sel), .fail(fail), .at_last(at_last), .at_sc_word(at_sc_word),
    .drv_ack_pin(drv_ack_pin), .status_q(status_q));

  task automatic cmp_w(input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  function automatic rmsc_pkg::rmsc_req_t rd(input logic [15:0] idn);
    return rmsc_pkg::rmsc_req_t'{1'b0, 3'h1, idn, 16'h0000};
  endfunction

  task automatic cfg(input logic [2:0] element_selector, input logic [7:0] words);
    @(posedge mclk);
    cyc_cfg_wr <= 1'b1;
    cyc_cfg_element_selector <= element_selector;
    cyc_cfg_words <= words;
    @(posedge mclk);
    cyc_cfg_wr <= 1'b0;
    @(posedge mclk);
    rej = cyc_cfg_rej;
  endtask

  task automatic wait_phases(input logic [4:0] exp);
    for (i = 0; i < 3000 && phase_done !== exp; i++) @(posedge mclk);
    cmp_w({12'h000, phase_done}, {12'h000, exp});
  endtask

  task automatic wait_rsp(input int n);
    for (i = 0; i < 4000 && rsp_q.size() < n; i++) @(posedge mclk);
    cmp_w(17'(rsp_q.size()), 17'(n));
  endtask

  task automatic t_reset;
    cmp_w({1'b0, tg_len}, 17'h00001);
    cmp_w({12'h000, phase_done}, 17'h00000);
    cmp_w({16'h0000, lad_ready}, 17'h00001);
    $display("test reset done");
  endtask

  task automatic t_order;
    rsp_q.delete();
    @(posedge mclk);
    lad_valid <= 1'b1;
    lad_req <= rd(16'h0031);
    @(posedge mclk);
    lad_req <= rd(16'h0032);
    @(posedge mclk);
    lad_valid <= 1'b0;
    tool_valid <= 1'b1;
    tool_req <= rd(16'h0040);
    for (i = 0; i < 3000 && tool_ready !== 1'b1; i++) @(posedge mclk);
    tool_valid <= 1'b0;
    wait_rsp(3);
    cmp_w(rsp_q[0], 17'h000ce);
    cmp_w(rsp_q[1], 17'h000cd);
    cmp_w(rsp_q[2], 17'h100bf);
    $display("test order done");
  endtask

  task automatic t_startup;
    ring_ok_pin <= 1'b1;
    cfg(3'h1, 8'h04);
    cmp_w({16'h0000, rej}, 17'h00000);
    cmp_w({9'h000, cyc_words}, 17'h00004);
    cfg(3'h2, 8'h02);
    cmp_w({16'h0000, rej}, 17'h00001);
    wait_phases(5'h03);
    step_done <= 1'b1;
    tick(1);
    step_done <= 1'b0;
    wait_phases(5'h07);
    tick(40);
    step_done <= 1'b1;
    tick(1);
    step_done <= 1'b0;
    tick(40);
    cmp_w({12'h000, phase_done}, 17'h00007);
    t_order;
    cont_req <= 1'b1;
    tick(1);
    cont_req <= 1'b0;
    repeat (2) begin
      tick(30);
      step_done <= 1'b1;
      tick(1);
      step_done <= 1'b0;
    end
    wait_phases(5'h1f);
    cmp_w(17'(early_n), 17'h00000);
    tick(40);
    cmp_w({1'b0, tg_len}, 17'h00005);
    cmp_w({16'h0000, xfer_n > 0}, 17'h00001);
    cfg(3'h1, 8'h06);
    cmp_w({16'h0000, rej}, 17'h00001);
    cmp_w({9'h000, cyc_words}, 17'h00004);
    $display("test startup done");
  endtask

  task automatic t_fill;
    cyc_en <= 1'b0;
    tick(40);
    rsp_q.delete();
    acc = 0;
    lad_valid <= 1'b1;
    for (int k = 0; k < 17; k++) begin
      lad_req <= rd(16'h0200 + 16'(k));
      @(posedge mclk);
      if (lad_ready === 1'b1) acc++;
    end
    lad_valid <= 1'b0;
    tick(2);
    cmp_w(17'(acc), 17'h00010);
    cmp_w({16'h0000, lad_ready}, 17'h00000);
    cmp_w(17'(rej_n), 17'h00001);
    cyc_en <= 1'b1;
    wait_rsp(16);
    for (int k = 0; k < 16; k++)
      cmp_w(rsp_q[k], {1'b0, 16'h02ff ^ 16'(k)});
    $display("test fill done");
  endtask

  task automatic t_proc(input logic bad);
    fail <= bad;
    run_n = 0;
    @(posedge mclk);
    pc_start <= 1'b1;
    @(posedge mclk);
    pc_start <= 1'b0;
    for (i = 0; i < 8000 && pc_done !== 1'b1; i++) @(posedge mclk);
    cmp_w({16'h0000, pc_err}, {16'h0000, bad});
    cmp_w({11'h000, pc_status}, bad ? 17'h0002b : 17'h00023);
    cmp_w({16'h0000, pc_busy}, 17'h00000);
    cmp_w({16'h0000, run_n > 0}, 17'h00001);
    cmp_w({1'b0, status_q}, 17'h00000);
    $display("test procedure done");
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    {mclk, rst_n, ring_ok_pin, cyc_start, cont_req, step_done, fail} = '0;
    {cyc_cfg_wr, lad_valid, tool_valid, pc_start, cyc_cfg_element_selector, cyc_cfg_words} = '0;
    {cnt_q, lad_req, tool_req} = '0;
    ce = 1'b1;
    hold_cfg = 1'b1;
    cyc_en = 1'b1;
    num_drv = 8'h02;
    pc_idn = PC_IDN;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    t_reset;
    t_startup;
    t_fill;
    t_proc(1'b0);
    t_proc(1'b1);
    finish_test;
  end

  initial begin
    #(20000 * 100);
    mismatches++;
    finish_test;
  end
endmodule
